// ### ancsp_cfg.svh
// Purpose: constants of the ancillary stream port and trigger block
// Assumes: 50 MHz sys_clk
// Notes:   included by ancsp_pacer and ancsp_top
`ifndef ANCSP_CFG_SVH
`define ANCSP_CFG_SVH

`define ANCSP_NSTREAM          4
`define ANCSP_NPIN             8
`define ANCSP_SER_BITS_PER_BYTE 32'h0000000A
`define ANCSP_FR_SCALE         32'h00000064
`define ANCSP_SCTE_DID         8'h41
`define ANCSP_SCTE_SDID        8'h07
`define ANCSP_SPLICE_OPID      16'h0101
`define ANCSP_XOFF_MARGIN      16'h0004
`define ANCSP_CLK_NS           20
`define ANCSP_MS_NS            1000000
`define ANCSP_SEC_NS           1000000000
`define ANCSP_MS_CYCLES        (`ANCSP_MS_NS / `ANCSP_CLK_NS)
`define ANCSP_SEC_CYCLES       (`ANCSP_SEC_NS / `ANCSP_CLK_NS)

`endif

// ### ancsp_pkg.sv
// Purpose: types of the ancillary stream port and trigger block
// Assumes: nothing
// Notes:   constants live in ancsp_cfg.svh
package ancsp_pkg;

  typedef enum logic [2:0] {
    ANCSP_DIS = 3'b001,
    ANCSP_ENC = 3'b010,
    ANCSP_DEC = 3'b100
  } ancsp_mode_t;

  typedef enum logic [1:0] {
    ANCSP_ST_OK       = 2'h0,
    ANCSP_ST_NO_PORT  = 2'h1,
    ANCSP_ST_OVERRUN  = 2'h2,
    ANCSP_ST_CONFLICT = 2'h3
  } ancsp_code_t;

  typedef struct packed {
    ancsp_mode_t mode;
    logic [7:0]  did;
    logic [7:0]  sdid;
    logic        use_serial;
    logic        port_assigned;
    logic        alarm_en;
    logic [15:0] data_count;
  } ancsp_cfg_t;

  typedef struct packed {
    ancsp_mode_t mode;
    logic [7:0]  did;
    logic [7:0]  sdid;
    ancsp_code_t code;
    logic [31:0] rate_bps;
    logic [10:0] line;
    logic        chroma;
    logic        field2;
    logic        hanc;
  } ancsp_stat_t;

  typedef struct packed {
    logic        sop;
    logic [7:0]  did;
    logic [7:0]  sdid;
    logic [7:0]  data;
    logic [10:0] line;
    logic        chroma;
    logic        field2;
    logic        hanc;
  } ancsp_anc_t;

  typedef struct packed {
    logic [2:0] pin;
    logic [7:0] did;
    logic [7:0] sdid;
  } ancsp_trig_t;

  typedef struct packed {
    logic [63:0] utc;
    logic [15:0] opid;
  } ancsp_log_t;

endpackage

// ### ancsp_pacer.sv
// Purpose: per-field byte credit for one encode stream
// Assumes: field_start is one pulse per field or frame
// Notes:   serial source cannot stall, so refused bytes are counted lost
`timescale 1ns/1ps
`include "ancsp_cfg.svh"
module ancsp_pacer
  import ancsp_pkg::*;
(
  input  wire logic        sys_clk,     // system clock
  input  wire logic        resetn,      // async reset, low
  input  wire logic        field_start, // field boundary pulse
  input  wire logic [15:0] data_count,  // bytes allowed per field
  input  wire logic        serial_mode, // source is the serial port
  input  wire logic        src_valid,   // source byte present
  input  wire logic [7:0]  src_data,    // source byte
  output logic             src_ready,   // byte may be taken
  output logic             xoff,        // ask sender to pause
  output logic             lost,        // serial byte dropped
  output logic             taken,       // byte accepted
  output logic             out_valid,   // byte to inserter
  output logic [7:0]       out_data,    // byte to inserter
  input  wire logic        out_ready    // inserter takes byte
);
  logic [15:0] credit_q, credit_d;
  logic        hold_q;
  logic [7:0]  data_q;

  assign src_ready = (credit_q != 16'h0000) && (!hold_q || out_ready);
  assign taken     = src_valid && src_ready;
  assign lost      = serial_mode && src_valid && !src_ready;
  assign xoff      = serial_mode && (credit_q <= `ANCSP_XOFF_MARGIN);
  assign credit_d  = field_start ? data_count - {15'h0000, taken}
                                 : credit_q - {15'h0000, taken};
  assign out_valid = hold_q;
  assign out_data  = data_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      credit_q <= 16'h0000;
      hold_q   <= 1'b0;
      data_q   <= 8'h00;
    end else begin
      credit_q <= credit_d;
      hold_q   <= taken || (hold_q && !out_ready);
      if (taken) data_q <= src_data;
    end
  end

  // helper: bytes taken since the last boundary
  logic [15:0] per_field_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) per_field_q <= 16'h0000;
    else per_field_q <= (field_start ? 16'h0000 : per_field_q) + {15'h0000, taken};
  end

  AST_FIELD_LIMIT: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(field_start) |-> per_field_q <= $past(data_count) + 16'h0001)
    else $error("more bytes than data_count in one field");
  AST_XOFF_EMPTY: assert property (@(posedge sys_clk) disable iff (!resetn)
    serial_mode && credit_q == 16'h0000 |-> xoff && !src_ready)
    else $error("no credit but serial not paused");
  AST_LOST: assert property (@(posedge sys_clk) disable iff (!resetn)
    serial_mode && src_valid && credit_q == 16'h0000 |-> lost)
    else $error("excess serial byte not flagged lost");
endmodule // ancsp_pacer

// ### ancsp_trig_out.sv
// Purpose: one trigger output pulse with its own timeout
// Assumes: ms_tick is one pulse per millisecond
// Notes:   a new load restarts the pulse
`timescale 1ns/1ps
module ancsp_trig_out (
  input  wire logic        sys_clk,  // system clock
  input  wire logic        resetn,   // async reset, low
  input  wire logic        load,     // matching packet decoded
  input  wire logic [15:0] width_ms, // pulse width in ms
  input  wire logic        ms_tick,  // millisecond tick
  output logic             pulse     // trigger output level
);
  logic [15:0] count_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= 16'h0000;
      pulse   <= 1'b0;
    end else begin
      if (load) count_q <= width_ms;
      else if (ms_tick && count_q != 16'h0000) count_q <= count_q - 16'h0001;
      pulse <= load ? (width_ms != 16'h0000) : (count_q != 16'h0000);
    end
  end

  AST_PULSE_START: assert property (@(posedge sys_clk) disable iff (!resetn)
    load && width_ms != 16'h0000 |=> pulse)
    else $error("trigger output did not assert on match");
  AST_PULSE_END: assert property (@(posedge sys_clk) disable iff (!resetn)
    !load && count_q == 16'h0000 |=> !pulse)
    else $error("trigger output held past its timeout");
endmodule // ancsp_trig_out

// ### ancsp_top.sv
// Purpose: stream ports, pacing, status and SCTE 104 triggers
// Assumes: all inputs synchronous to sys_clk
// Notes:   config is loose ports; cfg_load marks a new stream setup
// Operation
// - four streams, one may own serial port
// - serial pacing limited to min baud, rate
// - ten serial bit periods per byte
// - XOFF when reserved credit falls to four bytes
// - network stream carries data_count bytes per field
// - alarm clear hides stream errors
// - status refreshed on new stream configuration
// - encode status: mode, ids, state, rate
// - decode status: ids, state, rate, location
// - encode direction makes pins trigger inputs
// - pin message deferred past data-port field
// - trigger state held until event expires
// - decode direction makes pins mapped outputs
// - output pulses on PID, ends after timeout
// - trigger packets use fixed identifiers
// - log only splice requests with UTC
// - decode captures matching packet anywhere
// - SCTE 104 encode or decode, never both
`timescale 1ns/1ps
`include "ancsp_cfg.svh"
module ancsp_top
  import ancsp_pkg::*;
#(
  parameter int NSTREAM    = `ANCSP_NSTREAM,
  parameter int NPIN       = `ANCSP_NPIN,
  parameter int MS_CYCLES  = `ANCSP_MS_CYCLES,
  parameter int SEC_CYCLES = `ANCSP_SEC_CYCLES
) (
  input  wire logic                    sys_clk,         // system clock
  input  wire logic                    resetn,          // async reset, low
  input  wire ancsp_cfg_t [NSTREAM-1:0] stream_cfg,     // per-stream setup
  input  wire logic                    cfg_load,        // new stream configured
  input  wire logic [13:0]             field_rate,      // fields/s x100
  input  wire logic [17:0]             serial_baud,     // serial bit rate
  input  wire logic                    field_start,     // field boundary pulse
  input  wire logic [NSTREAM-1:0]      net_valid,       // network byte present
  input  wire logic [NSTREAM*8-1:0]    net_data,        // network bytes
  output logic [NSTREAM-1:0]           net_ready,       // network byte taken
  input  wire logic                    ser_rx_valid,    // serial byte received
  input  wire logic [7:0]              ser_rx_data,     // serial byte
  output logic                         ser_xoff,        // pause serial sender
  output logic [31:0]                  serial_rate_limit, // bit/s x100
  output logic [NSTREAM-1:0]           ins_valid,       // byte to inserter
  output logic [NSTREAM*8-1:0]         ins_data,        // bytes to inserter
  input  wire logic [NSTREAM-1:0]      ins_ready,       // inserter takes byte
  input  wire logic                    anc_valid,       // ancillary word valid
  input  wire ancsp_anc_t              anc_word,        // ancillary word
  output logic [NSTREAM-1:0]           dec_valid,       // extracted byte valid
  output logic [7:0]                   dec_data,        // extracted byte
  output ancsp_stat_t [NSTREAM-1:0]    stream_stat,     // per-stream status
  input  wire logic                    scte_decode,     // 1 decode, 0 encode
  input  wire logic [NPIN-1:0]         trigger_input,   // pin levels in
  output logic [NPIN-1:0]              trigger_output,  // pin levels out
  output logic [NPIN-1:0]              trigger_oe,      // pin drive enable
  input  wire logic                    dp_msg_valid,    // data-port message
  input  wire logic [NPIN-1:0]         trig_expire,     // pin event expired
  output logic                         trig_req_valid,  // pin message request
  output ancsp_trig_t                  trig_req,        // pin message fields
  input  wire logic                    ts_valid,        // decoded packet pulse
  input  wire logic [NPIN*13-1:0]      pin_pid,         // PID per pin
  input  wire logic [NPIN*16-1:0]      pin_width_ms,    // pulse width per pin
  input  wire logic [12:0]             ts_pid,          // decoded PID
  input  wire logic                    msg_valid,       // decoded message
  input  wire logic [15:0]             msg_opid,        // message opcode
  input  wire logic [63:0]             utc_time,        // network time, UTC
  output logic                         log_valid,       // log entry strobe
  output ancsp_log_t                   log_entry        // log entry
);
  // ---------------- serial ownership and pacing ----------------
  logic [NSTREAM:0]   ser_below;
  logic [NSTREAM-1:0] ser_own, conflict, is_enc, is_dec, xoff, lost, taken;
  logic [NSTREAM-1:0] pace_valid, pace_ready;
  logic [NSTREAM*8-1:0] pace_data;
  logic [NSTREAM*32-1:0] lim_all;
  logic [31:0] lim_or [NSTREAM:0];

  assign ser_below[0] = 1'b0;
  assign lim_or[0]    = 32'h00000000;

  genvar gi;
  generate
    for (gi = 0; gi < NSTREAM; gi++) begin : g_str
      logic [31:0] lim_rate, lim_baud;
      assign is_enc[gi]      = stream_cfg[gi].mode == ANCSP_ENC;
      assign is_dec[gi]      = stream_cfg[gi].mode == ANCSP_DEC;
      assign ser_own[gi]     = is_enc[gi] && stream_cfg[gi].use_serial
                               && !ser_below[gi];
      assign conflict[gi]    = stream_cfg[gi].use_serial && ser_below[gi];
      assign ser_below[gi+1] = ser_below[gi]
                               || (stream_cfg[gi].mode != ANCSP_DIS && stream_cfg[gi].use_serial);
      assign pace_valid[gi]  = is_enc[gi] && (ser_own[gi] ? ser_rx_valid : net_valid[gi]);
      assign pace_data[gi*8 +: 8] = ser_own[gi] ? ser_rx_data : net_data[gi*8 +: 8];
      assign net_ready[gi]   = pace_ready[gi] && is_enc[gi] && !ser_own[gi];
      // limit = min(baud, field_rate x 10 x data_count), in hundredths
      assign lim_rate = 32'(field_rate) * `ANCSP_SER_BITS_PER_BYTE
                        * 32'(stream_cfg[gi].data_count);
      assign lim_baud = 32'(serial_baud) * `ANCSP_FR_SCALE;
      assign lim_all[gi*32 +: 32] = (lim_baud < lim_rate) ? lim_baud : lim_rate;
      assign lim_or[gi+1] = lim_or[gi] | (ser_own[gi] ? lim_all[gi*32 +: 32] : 32'h00000000);

      ancsp_pacer u_pacer (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .field_start (field_start),
        .data_count  (stream_cfg[gi].data_count),
        .serial_mode (ser_own[gi]),
        .src_valid   (pace_valid[gi]),
        .src_data    (pace_data[gi*8 +: 8]),
        .src_ready   (pace_ready[gi]),
        .xoff        (xoff[gi]),
        .lost        (lost[gi]),
        .taken       (taken[gi]),
        .out_valid   (ins_valid[gi]),
        .out_data    (ins_data[gi*8 +: 8]),
        .out_ready   (ins_ready[gi])
      );
    end
  endgenerate

  assign ser_xoff          = |(xoff & ser_own);
  assign serial_rate_limit = lim_or[NSTREAM];

  // ---------------- decode capture ----------------
  logic [NSTREAM-1:0] match_q, dec_valid_q;
  logic [NSTREAM-1:0] hit_now, fwd_now;
  logic [7:0]         dec_data_q;

  generate
    for (gi = 0; gi < NSTREAM; gi++) begin : g_dec
      assign hit_now[gi] = anc_valid && anc_word.sop && is_dec[gi]
                           && anc_word.did == stream_cfg[gi].did
                           && anc_word.sdid == stream_cfg[gi].sdid;
      assign fwd_now[gi] = anc_valid && (hit_now[gi] || (match_q[gi] && !anc_word.sop));
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      match_q     <= '0;
      dec_valid_q <= '0;
      dec_data_q  <= 8'h00;
    end else begin
      if (anc_valid && anc_word.sop) match_q <= hit_now;
      dec_valid_q <= fwd_now;
      if (|fwd_now) dec_data_q <= anc_word.data;
    end
  end

  assign dec_valid = dec_valid_q;
  assign dec_data  = dec_data_q;

  // ---------------- rate measurement and status ----------------
  logic [31:0]        sec_cnt_q;
  logic               sec_end;
  logic [NSTREAM-1:0] overrun_q;
  logic [NSTREAM-1:0] byte_evt;

  assign sec_end  = sec_cnt_q == 32'(SEC_CYCLES - 1);
  assign byte_evt = taken | fwd_now;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) sec_cnt_q <= 32'h00000000;
    else sec_cnt_q <= sec_end ? 32'h00000000 : sec_cnt_q + 32'h00000001;
  end

  generate
    for (gi = 0; gi < NSTREAM; gi++) begin : g_stat
      logic [31:0] bytes_q, rate_q;
      logic [10:0] line_q;
      logic        chroma_q, field2_q, hanc_q;
      ancsp_code_t code;

      // set wins over the refresh clear
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) overrun_q[gi] <= 1'b0;
        else overrun_q[gi] <= lost[gi] || (overrun_q[gi] && !cfg_load);
      end

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          bytes_q <= 32'h00000000;
          rate_q  <= 32'h00000000;
        end else begin
          bytes_q <= (sec_end || cfg_load ? 32'h00000000 : bytes_q)
                     + {31'h00000000, byte_evt[gi]};
          if (cfg_load) rate_q <= 32'h00000000;
          else if (sec_end) rate_q <= bytes_q + {31'h00000000, byte_evt[gi]};
        end
      end

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          line_q   <= 11'h000;
          chroma_q <= 1'b0;
          field2_q <= 1'b0;
          hanc_q   <= 1'b0;
        end else if (hit_now[gi]) begin
          line_q   <= anc_word.line;
          chroma_q <= anc_word.chroma;
          field2_q <= anc_word.field2;
          hanc_q   <= anc_word.hanc;
        end
      end

      assign code = !stream_cfg[gi].alarm_en || stream_cfg[gi].mode == ANCSP_DIS
                      ? ANCSP_ST_OK
                  : conflict[gi]                   ? ANCSP_ST_CONFLICT
                  : !stream_cfg[gi].port_assigned  ? ANCSP_ST_NO_PORT
                  : overrun_q[gi]                  ? ANCSP_ST_OVERRUN
                  :                                  ANCSP_ST_OK;

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) stream_stat[gi] <= '0;
        else begin
          stream_stat[gi].mode     <= stream_cfg[gi].mode;
          stream_stat[gi].did      <= stream_cfg[gi].did;
          stream_stat[gi].sdid     <= stream_cfg[gi].sdid;
          stream_stat[gi].code     <= code;
          stream_stat[gi].rate_bps <= rate_q;
          stream_stat[gi].line     <= line_q;
          stream_stat[gi].chroma   <= chroma_q;
          stream_stat[gi].field2   <= field2_q;
          stream_stat[gi].hanc     <= hanc_q;
        end
      end

      AST_ALARM_MASK: assert property (@(posedge sys_clk) disable iff (!resetn)
        !stream_cfg[gi].alarm_en ##1 !stream_cfg[gi].alarm_en
        |-> stream_stat[gi].code == ANCSP_ST_OK)
        else $error("error shown with alarm disabled");
    end
  endgenerate

  // ---------------- encode triggers ----------------
  logic [NPIN-1:0] pin_prev_q, pend_q, trig_state_q, pin_rise, pick, trig_keep;
  logic            dp_field_q, grant;
  logic [2:0]      pick_idx;

  assign pin_rise = trigger_input & ~pin_prev_q & {NPIN{!scte_decode}};
  assign pick     = pend_q & (~pend_q + {{(NPIN-1){1'b0}}, 1'b1});
  assign grant    = field_start && !dp_field_q && (|pend_q);
  assign trig_keep = trig_state_q & ~trig_expire;

  always_comb begin
    pick_idx = 3'h0;
    for (int k = 0; k < NPIN; k++) begin
      if (pick[k]) pick_idx = 3'(k);
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_prev_q     <= '0;
      pend_q         <= '0;
      trig_state_q   <= '0;
      dp_field_q     <= 1'b0;
      trig_req_valid <= 1'b0;
      trig_req       <= '0;
    end else begin
      pin_prev_q   <= trigger_input;
      pend_q       <= pin_rise | (pend_q & ~(pick & {NPIN{grant}}));
      trig_state_q <= pin_rise | (trig_state_q & ~trig_expire);
      dp_field_q   <= dp_msg_valid || (dp_field_q && !field_start);
      trig_req_valid <= grant && !scte_decode;
      if (grant) begin
        trig_req.pin  <= pick_idx;
        trig_req.did  <= `ANCSP_SCTE_DID;
        trig_req.sdid <= `ANCSP_SCTE_SDID;
      end
    end
  end

  // ---------------- decode triggers ----------------
  logic [15:0]     ms_cnt_q;
  logic            ms_tick;
  logic [NPIN-1:0] pulse;

  assign ms_tick = ms_cnt_q == 16'(MS_CYCLES - 1);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) ms_cnt_q <= 16'h0000;
    else ms_cnt_q <= ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
  end

  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      ancsp_trig_out u_out (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .load     (scte_decode && ts_valid && ts_pid == pin_pid[gi*13 +: 13]),
        .width_ms (pin_width_ms[gi*16 +: 16]),
        .ms_tick  (ms_tick),
        .pulse    (pulse[gi])
      );
    end
  endgenerate

  assign trigger_output = pulse & {NPIN{scte_decode}};
  assign trigger_oe     = {NPIN{scte_decode}};

  // ---------------- splice event log ----------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      log_valid <= 1'b0;
      log_entry <= '0;
    end else begin
      log_valid <= msg_valid && msg_opid == `ANCSP_SPLICE_OPID;
      if (msg_valid) log_entry <= '{utc: utc_time, opid: msg_opid};
    end
  end

  sequence s_pin_rise_in_dp_field;
    dp_msg_valid ##0 (|pin_rise) ##1 !field_start [*1];
  endsequence

  AST_ONE_SERIAL: assert property (@(posedge sys_clk) disable iff (!resetn)
    $onehot0(ser_own))
    else $error("more than one stream owns the serial port");
  AST_PIN_DEFER: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_pin_rise_in_dp_field ##1 field_start |=> !trig_req_valid)
    else $error("pin message inserted in data-port field");
  AST_TRIG_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
    |trig_keep |=> (trig_state_q & $past(trig_keep)) == $past(trig_keep))
    else $error("trigger state dropped before expiry");
  AST_DIR_EXCL: assert property (@(posedge sys_clk) disable iff (!resetn)
    !scte_decode |-> trigger_oe == '0 && trigger_output == '0)
    else $error("pins driven in encode direction");
  AST_LOG_SPLICE: assert property (@(posedge sys_clk) disable iff (!resetn)
    log_valid |-> log_entry.opid == `ANCSP_SPLICE_OPID && $past(msg_valid))
    else $error("non-splice message logged");
endmodule // ancsp_top

// ### ancsp_sender.sv
// Purpose: data-port sender standing for the outside computer
// Assumes: a byte is handed over at an edge with ready high
// Notes:   pauses on request, otherwise sends a rising count
`timescale 1ns/1ps
module ancsp_sender (
  input  wire logic  sys_clk, // system clock
  input  wire logic  go,      // allowed to send
  input  wire logic  ready,   // byte taken
  input  wire logic  xoff,    // pause request
  output logic       valid,   // byte present
  output logic [7:0] data     // byte, inverted when idle
);
  logic [7:0] cnt_q;
  initial begin
    valid = 1'b0;
    cnt_q = 8'h00;
  end
  assign data = valid ? cnt_q : ~cnt_q;
  always @(posedge sys_clk) begin
    if (valid && ready) cnt_q <= cnt_q + 8'h01;
    if (!valid || ready) valid <= go && !xoff;
  end
endmodule // ancsp_sender

// ### tb_ancsp_top.sv
// Purpose: self-checking bench of ancsp_top
// Assumes: timers shortened to 10 and 100 cycles
// Notes:   two senders feed the network and serial ports
`timescale 1ns/1ps
module tb_ancsp_top;
  import ancsp_pkg::*;
  typedef struct {logic [12:0] pid; int pin; logic exp;} ancsp_row_t;
  logic sys_clk, resetn, cfg_load, field_start, scte_decode, dp_msg_valid, go, nv;
  logic ts_valid, msg_valid, ser_rx_valid, ser_xoff, trig_req_valid, log_valid;
  logic [7:0]   trigger_input, trigger_output, trigger_oe, nd, ser_rx_data;
  logic [12:0]  ts_pid;
  logic [15:0]  msg_opid;
  logic [3:0]   net_ready, ins_valid, dec_valid;
  logic [31:0]  serial_rate_limit, ins_data;
  logic [7:0]   trig_expire, dec_data;
  logic         anc_valid;
  ancsp_anc_t   anc_word;
  logic [103:0] pin_pid;
  logic [127:0] pin_width_ms;
  logic [13:0]  field_rate = 14'h176A;
  logic [17:0]  serial_baud = 18'h02580;
  logic [63:0]  utc_time = 64'h0123456789ABCDEF;
  ancsp_cfg_t [3:0]  stream_cfg;
  ancsp_stat_t [3:0] stream_stat;
  ancsp_trig_t       trig_req, tq;
  ancsp_log_t        log_entry, lq;
  int n_errors, checks_done, n_ins, n_trig, n_log;
  ancsp_row_t rows[4] = '{'{13'h100, 0, 1'b1}, '{13'h103, 3, 1'b1},
                          '{13'h107, 7, 1'b1}, '{13'h0FF, 1, 1'b0}};
  ancsp_top #(.MS_CYCLES(10), .SEC_CYCLES(100)) u_ancsp_top (
    .sys_clk, .resetn, .stream_cfg, .cfg_load, .field_rate, .serial_baud, .field_start,
    .net_valid({3'h0, nv}), .net_data({24'h0, nd}), .net_ready, .ser_rx_valid,
    .ser_rx_data, .ser_xoff, .serial_rate_limit, .ins_valid, .ins_data,
    .ins_ready(4'hF), .anc_valid, .anc_word, .dec_valid, .dec_data,
    .stream_stat, .scte_decode, .trigger_input, .trigger_output, .trigger_oe,
    .dp_msg_valid, .trig_expire, .trig_req_valid, .trig_req, .ts_valid, .pin_pid,
    .pin_width_ms, .ts_pid, .msg_valid, .msg_opid, .utc_time, .log_valid, .log_entry);
  ancsp_sender u_net (.sys_clk, .go, .ready(net_ready[0]), .xoff(1'b0), .valid(nv), .data(nd));
  ancsp_sender u_ser (.sys_clk, .go, .ready(1'b1), .xoff(ser_xoff), .valid(ser_rx_valid),
                      .data(ser_rx_data));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (ins_valid[0]) begin
      chk(ins_data[7:0], n_ins[7:0]);
      n_ins++;
    end
    if (trig_req_valid) begin
      n_trig++;
      tq <= trig_req;
    end
    if (log_valid) begin
      n_log++;
      lq <= log_entry;
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic field;
    @(posedge sys_clk) field_start <= 1'b1;
    @(posedge sys_clk) field_start <= 1'b0;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic complete_run;
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  initial begin
    {resetn, cfg_load, field_start, dp_msg_valid, go, ts_valid, msg_valid} = '0;
    {trigger_input, ts_pid, msg_opid, trig_expire, anc_valid, anc_word} = '0;
    scte_decode = 1'b1;
    for (int i = 0; i < 8; i++) begin
      pin_pid[13*i +: 13] = 13'h100 + 13'(i);
      pin_width_ms[16*i +: 16] = 16'(i + 1);
    end
    stream_cfg[0] = '{ANCSP_ENC, 8'h61, 8'h01, 1'b0, 1'b1, 1'b1, 16'h0005};
    stream_cfg[1] = '{ANCSP_ENC, 8'h10, 8'h01, 1'b1, 1'b1, 1'b1, 16'h0008};
    stream_cfg[2] = '{ANCSP_ENC, 8'h12, 8'h34, 1'b1, 1'b1, 1'b0, 16'h0001};
    stream_cfg[3] = '{ANCSP_ENC, 8'h12, 8'h35, 1'b1, 1'b1, 1'b1, 16'h0001};
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    chk(net_ready, 64'h0);
    chk(trigger_oe, 64'hFF);
    foreach (rows[i]) begin
      @(posedge sys_clk) {ts_valid, ts_pid} <= {1'b1, rows[i].pid};
      @(posedge sys_clk) ts_valid <= 1'b0;
      @(negedge sys_clk) chk(trigger_output[rows[i].pin], rows[i].exp);
    end
    repeat (30) @(posedge sys_clk);
    @(negedge sys_clk) chk(trigger_output[0], 64'h0);
    chk(trigger_output[7], 64'h1);
    @(posedge sys_clk) {scte_decode, cfg_load} <= 2'b01;
    @(posedge sys_clk) {cfg_load, go, dp_msg_valid, trigger_input} <= {3'b011, 8'h04};
    @(posedge sys_clk) dp_msg_valid <= 1'b0;
    @(negedge sys_clk) chk(trigger_oe, 64'h0);
    field();
    chk(n_ins, 64'h5);
    chk(n_trig, 64'h0);
    field();
    chk(n_ins, 64'hA);
    chk({n_trig[3:0], tq}, {4'h1, 3'h2, 8'h41, 8'h07});
    chk(serial_rate_limit, 64'h75120);
    chk(ser_xoff, 64'h1);
    chk(stream_stat[1].code, ANCSP_ST_OK);
    chk(stream_stat[2].code, ANCSP_ST_OK);
    chk(stream_stat[3].code, ANCSP_ST_CONFLICT);
    chk({stream_stat[0].mode, stream_stat[0].did}, {ANCSP_ENC, 8'h61});
    chk(u_ancsp_top.trig_state_q, 64'h4);
    @(posedge sys_clk) trig_expire <= 8'h04;
    @(posedge sys_clk) trig_expire <= 8'h00;
    @(negedge sys_clk) chk(u_ancsp_top.trig_state_q, 64'h0);
    @(posedge sys_clk) {msg_valid, msg_opid} <= {1'b1, 16'h0202};
    @(posedge sys_clk) msg_opid <= 16'h0101;
    @(posedge sys_clk) msg_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) chk({n_log[3:0], lq.opid}, {4'h1, 16'h0101});
    chk(lq.utc, utc_time);
    @(posedge sys_clk) stream_cfg[0] <= '{ANCSP_DEC, 8'h12, 8'h34, 1'b0, 1'b1, 1'b1, 16'h0005};
    @(posedge sys_clk) {anc_valid, anc_word} <= {2'b11, 16'h1234, 8'h12, 11'h00A, 3'b110};
    @(posedge sys_clk) anc_word <= {1'b0, 16'h1234, 8'hA5, 14'h0000};
    @(negedge sys_clk) chk({dec_valid, dec_data}, 64'h112);
    @(posedge sys_clk) anc_valid <= 1'b0;
    @(negedge sys_clk) chk({dec_valid, dec_data}, 64'h1A5);
    chk({stream_stat[0].line, stream_stat[0].chroma, stream_stat[0].field2}, 64'h2B);
    @(posedge sys_clk) resetn <= 1'b0;
    @(negedge sys_clk) chk({ins_valid, trig_req_valid, log_valid}, 64'h0);
    @(posedge sys_clk) resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) chk({net_ready, ser_xoff, ins_valid}, 64'h10);
    complete_run();
  end
endmodule // tb_ancsp_top
